// >>> logic/cse_pkg.sv
// How it works
// - Any internal character parity failure halts and lights stop and parity.
// - Fetch-phase parity failure lights instruction phase and commits nothing.
// - Source-phase parity failure lights the source-phase indicator.
// - Source-phase error during read-out-and-reset leaves accumulator zero, old value in core.
// - Destination-phase parity failure lights destination phase; accumulation data held in core.
// - Timing out of step halts with clock error, possibly one step late.
// - Clock error clears only by full reset, never by check reset.
// - Disk write-back compare mismatch halts with file-check indicator.
// - Accumulator read-out-and-reset to disk always raises file check.
// - Unwired file panel raises file check on every disk write.
// - Card misfeed at any reader station halts with feed-check indicator.
// - Read or recode error on an input card halts with read check.
// - Read-check stop holds the last three cards in flight unprocessed.
// - Early buffer-track access halts with interlock and device select lit.
// - Check reset during a peripheral interlock abandons the interlocked instruction.
// - Mark-and-stop mode prints delta, lights check, stops at next output transfer.
// - Mark-and-continue prints delta, lights check, keeps printing, no console sign.
// - Plain stop mode prints no delta, lights check, stops at next output transfer.
// - Stopping modes finish the line, halt, light interlock and printer select.
// - Pending skip and multi_line_print orders are kept and run after reset.
// - After a stopping printer error, line-repeat reprints the current line.
package cse_pkg;
    // Instruction phases.
    localparam logic [1:0] PH_FETCH  = 2'h0;
    localparam logic [1:0] PH_SOURCE = 2'h1;
    localparam logic [1:0] PH_DEST   = 2'h2;
    // Select indicator bits.
    localparam int SEL_READER  = 0;
    localparam int SEL_PRINTER = 1;
    localparam int SEL_PUNCH   = 2;
    localparam int SEL_TYPE    = 3;
    localparam int SEL_W       = 4;
    // Printer error mode straps.
    localparam logic [1:0] PM_STOP      = 2'h0;
    localparam logic [1:0] PM_MARK_STOP = 2'h1;
    localparam logic [1:0] PM_MARK_CONT = 2'h2;
    // Reader pipeline depth held on a read check.
    localparam int CARDS_HELD = 3;
    localparam int CARD_W     = 8;
    // Pending printer order queue.
    localparam int ORD_W     = 8;
    localparam int ORD_DEPTH = 8;
    typedef enum {PR_IDLE, PR_PRINT, PR_HALT} cse_prn_type;
endpackage

// >>> logic/cse_mem.sv
`timescale 1ns/1ps
`default_nettype none
module cse_mem #(
    parameter int W     = 8,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic          clk,
    input  wire logic          ce,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [W-1:0]  wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [W-1:0]  rdata
);
    logic [W-1:0] mem [DEPTH];
    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end
    always_ff @(posedge clk) begin
        if (ce) begin
            rdata <= mem[raddr];
        end
    end
endmodule // cse_mem
`default_nettype wire

// >>> logic/cse_reader_hold.sv
`timescale 1ns/1ps
`default_nettype none
module cse_reader_hold #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    input  wire logic         card_in,
    input  wire logic [W-1:0] card_id,
    input  wire logic         hold,
    output logic      [W-1:0] held0_q,
    output logic      [W-1:0] held1_q,
    output logic      [W-1:0] held2_q
);
    // Three-deep shift of cards in flight; frozen while the stop holds.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            held0_q <= '0;
            held1_q <= '0;
            held2_q <= '0;
        end else if (ce && card_in && !hold) begin
            held0_q <= card_id;
            held1_q <= held0_q;
            held2_q <= held1_q;
        end
    end
endmodule // cse_reader_hold
`default_nettype wire

// >>> logic/cse_top.sv
`timescale 1ns/1ps
`default_nettype none
module cse_top #(
    parameter int ACC_W = 16
) (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    input  wire logic                    ce,
    input  wire logic                    check_reset,
    input  wire logic                    full_reset,
    input  wire logic                    parity_fail,
    input  wire logic [1:0]              phase,
    input  wire logic                    step_end,
    input  wire logic                    timing_fault,
    input  wire logic                    acc_readout_reset,
    input  wire logic                    acc_accumulate,
    input  wire logic [ACC_W-1:0]        acc_value,
    input  wire logic                    disk_write,
    input  wire logic                    disk_compare_ok,
    input  wire logic                    disk_from_acc_ror,
    input  wire logic                    file_panel_wired,
    input  wire logic                    feed_misfeed,
    input  wire logic                    read_error,
    input  wire logic                    card_in,
    input  wire logic [7:0]              card_id,
    input  wire logic                    input_track_access,
    input  wire logic                    feed_busy,
    input  wire logic                    output_track_write,
    input  wire logic [cse_pkg::SEL_W-1:0] output_busy,
    input  wire logic [cse_pkg::SEL_W-1:0] output_dev,
    input  wire logic                    periph_error,
    input  wire logic [1:0]              prn_mode,
    input  wire logic                    prn_error,
    input  wire logic                    prn_line_start,
    input  wire logic                    prn_line_done,
    input  wire logic                    prn_reset_check,
    input  wire logic                    line_repeat,
    input  wire logic                    order_push,
    input  wire logic [7:0]              order_code,
    output logic                         halt_q,
    output logic                         stop_ind_q,
    output logic                         parity_ind_q,
    output logic                         fetch_ind_q,
    output logic                         source_ind_q,
    output logic                         dest_ind_q,
    output logic                         clock_ind_q,
    output logic                         file_ind_q,
    output logic                         feed_ind_q,
    output logic                         read_ind_q,
    output logic                         ilock_ind_q,
    output logic [cse_pkg::SEL_W-1:0]    select_ind_q,
    output logic                         abandon_q,
    output logic                         commit_en_q,
    output logic                         acc_zero_q,
    output logic [ACC_W-1:0]             core_q,
    output logic                         prn_check_ind_q,
    output logic                         delta_mark_q,
    output logic                         prn_reprint_q,
    output logic                         prn_halt_q,
    output logic                         order_valid_q,
    output logic [7:0]                   order_out_q,
    output logic [7:0]                   held0_q,
    output logic [7:0]                   held1_q,
    output logic [7:0]                   held2_q
);
    localparam int AW = $clog2(cse_pkg::ORD_DEPTH);

    logic                       clear_chk;
    logic                       par_evt;
    logic                       file_evt;
    logic                       ilock_evt;
    logic [cse_pkg::SEL_W-1:0]  ilock_sel;
    logic                       prn_stopping;
    logic                       prn_pend_q;
    logic                       clk_pend_q;
    cse_pkg::cse_prn_type       prn_st_q;
    logic [AW-1:0]              wptr_q;
    logic [AW-1:0]              rptr_q;
    logic [AW:0]                cnt_q;
    logic                       rd_pend_q;
    logic [7:0]                 ord_rd;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = p + 1'b1;
    endfunction

    assign clear_chk    = check_reset || full_reset;
    assign par_evt      = parity_fail;
    // File check on mismatch, invalid accumulator source, or unwired panel.
    // file check cause.
    assign file_evt     = disk_write && (!disk_compare_ok || disk_from_acc_ror || !file_panel_wired);
    // Interlocks on early input or output buffer access.
    // interlock cause detect.
    assign ilock_sel    = ({cse_pkg::SEL_W{output_track_write}} & output_dev & output_busy)
                        | ({{(cse_pkg::SEL_W-1){1'b0}}, input_track_access && feed_busy});
    assign ilock_evt    = |ilock_sel;
    assign prn_stopping = (prn_mode != cse_pkg::PM_MARK_CONT);

    // Parity and phase indicators latch until a check or full reset; stop needs a full reset after a clock error.
    // parity halt latch.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            parity_ind_q <= 1'b0;
        end else if (ce) begin
            if (par_evt) begin
                parity_ind_q <= 1'b1;
            end else if (clear_chk) begin
                parity_ind_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fetch_ind_q  <= 1'b0;
            source_ind_q <= 1'b0;
            dest_ind_q   <= 1'b0;
        end else if (ce) begin
            if (par_evt) begin
                fetch_ind_q  <= fetch_ind_q  || (phase == cse_pkg::PH_FETCH);
                source_ind_q <= source_ind_q || (phase == cse_pkg::PH_SOURCE);
                dest_ind_q   <= dest_ind_q   || (phase == cse_pkg::PH_DEST);
            end else if (clear_chk) begin
                fetch_ind_q  <= 1'b0;
                source_ind_q <= 1'b0;
                dest_ind_q   <= 1'b0;
            end
        end
    end

    // Commit is blocked from any fetch-phase failure onward.
    // no commit on fetch.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            commit_en_q <= 1'b1;
        end else if (ce) begin
            if (par_evt || halt_q) begin
                commit_en_q <= 1'b0;
            end else if (clear_chk) begin
                commit_en_q <= 1'b1;
            end else begin
                commit_en_q <= 1'b1;
            end
        end
    end

    // Core store keeps the accumulator image; accumulator flag shows zero after read-out.
    // core retention.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            core_q     <= '0;
            acc_zero_q <= 1'b0;
        end else if (ce && !halt_q) begin
            if (acc_readout_reset || acc_accumulate) begin
                core_q <= acc_value;
            end
            if (acc_readout_reset) begin
                acc_zero_q <= 1'b1;
            end else if (acc_accumulate) begin
                acc_zero_q <= 1'b0;
            end
        end
    end

    // Timing fault is flagged at the end of the step, so possibly one step late.
    // clock error latch.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clk_pend_q  <= 1'b0;
            clock_ind_q <= 1'b0;
        end else if (ce) begin
            if (full_reset) begin
                clk_pend_q  <= 1'b0;
                clock_ind_q <= 1'b0;
            end else begin
                if (timing_fault) begin
                    clk_pend_q <= 1'b1;
                end else if (step_end) begin
                    clk_pend_q <= 1'b0;
                end
                if (step_end && (clk_pend_q || timing_fault)) begin
                    clock_ind_q <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            file_ind_q <= 1'b0;
        end else if (ce) begin
            if (file_evt) begin
                file_ind_q <= 1'b1;
            end else if (clear_chk) begin
                file_ind_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            feed_ind_q <= 1'b0;
            read_ind_q <= 1'b0;
        end else if (ce) begin
            if (feed_misfeed) begin
                feed_ind_q <= 1'b1;
            end else if (clear_chk) begin
                feed_ind_q <= 1'b0;
            end
            if (read_error) begin
                read_ind_q <= 1'b1;
            end else if (clear_chk) begin
                read_ind_q <= 1'b0;
            end
        end
    end

    cse_reader_hold #(
        .W       (cse_pkg::CARD_W)
    ) u_hold (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .card_in (card_in),
        .card_id (card_id),
        .hold    (read_ind_q || read_error),
        .held0_q (held0_q),
        .held1_q (held1_q),
        .held2_q (held2_q)
    );

    // Printer error state: stopping modes finish the line, then halt.
    // printer halt.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prn_st_q <= cse_pkg::PR_IDLE;
        end else if (ce) begin
            case (prn_st_q)
                cse_pkg::PR_IDLE: begin
                    if (prn_line_start) begin
                        prn_st_q <= cse_pkg::PR_PRINT;
                    end
                end
                cse_pkg::PR_PRINT: begin
                    if (prn_line_done) begin
                        prn_st_q <= (prn_pend_q && prn_stopping) ? cse_pkg::PR_HALT : cse_pkg::PR_IDLE;
                    end
                end
                cse_pkg::PR_HALT: begin
                    if (prn_reset_check || full_reset) begin
                        prn_st_q <= cse_pkg::PR_IDLE;
                    end
                end
                default: prn_st_q <= cse_pkg::PR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prn_pend_q      <= 1'b0;
            prn_check_ind_q <= 1'b0;
            delta_mark_q    <= 1'b0;
        end else if (ce) begin
            delta_mark_q <= prn_error && (prn_mode != cse_pkg::PM_STOP);
            if (prn_error) begin
                prn_pend_q      <= 1'b1;
                prn_check_ind_q <= 1'b1;
            end else if (prn_reset_check || full_reset) begin
                prn_pend_q      <= 1'b0;
                prn_check_ind_q <= 1'b0;
            end else if (prn_st_q == cse_pkg::PR_IDLE) begin
                prn_pend_q      <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prn_halt_q    <= 1'b0;
            prn_reprint_q <= 1'b0;
        end else if (ce) begin
            prn_halt_q    <= (prn_st_q == cse_pkg::PR_HALT);
            prn_reprint_q <= line_repeat && (prn_st_q == cse_pkg::PR_HALT);
        end
    end

    // Interlock and select lights, including the printer stopping modes at output transfer.
    // interlock latch.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ilock_ind_q  <= 1'b0;
            select_ind_q <= '0;
        end else if (ce) begin
            if (ilock_evt || (output_track_write && prn_halt_q)) begin
                ilock_ind_q  <= 1'b1;
                select_ind_q <= select_ind_q | ilock_sel
                              | (prn_halt_q ? 4'h2 : 4'h0);
            end else if (clear_chk) begin
                ilock_ind_q  <= 1'b0;
                select_ind_q <= '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            abandon_q <= 1'b0;
        end else if (ce) begin
            abandon_q <= check_reset && ilock_ind_q && periph_error;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            halt_q     <= 1'b0;
            stop_ind_q <= 1'b0;
        end else if (ce) begin
            if (par_evt || file_evt || feed_misfeed || read_error || ilock_evt
                || (step_end && (clk_pend_q || timing_fault))
                || (output_track_write && prn_halt_q)) begin
                halt_q     <= 1'b1;
                stop_ind_q <= 1'b1;
            end else if (full_reset || (check_reset && !clock_ind_q)) begin
                halt_q     <= 1'b0;
                stop_ind_q <= 1'b0;
            end
        end
    end

    // Pending skip and multi_line_print orders kept in order.
    // order retention.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wptr_q    <= '0;
            rptr_q    <= '0;
            cnt_q     <= '0;
            rd_pend_q <= 1'b0;
        end else if (ce) begin
            logic push;
            logic pop;
            push = order_push && (cnt_q != (AW+1)'(cse_pkg::ORD_DEPTH));
            pop  = (cnt_q != '0) && !prn_pend_q && (prn_st_q == cse_pkg::PR_IDLE) && !rd_pend_q;
            if (push) begin
                wptr_q <= ptr_inc(wptr_q);
            end
            if (pop) begin
                rptr_q <= ptr_inc(rptr_q);
            end
            rd_pend_q <= pop;
            cnt_q     <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    cse_mem #(
        .W     (cse_pkg::ORD_W),
        .DEPTH (cse_pkg::ORD_DEPTH),
        .AW    (AW)
    ) u_ord (
        .clk   (clk),
        .ce    (ce),
        .we    (order_push && (cnt_q != (AW+1)'(cse_pkg::ORD_DEPTH))),
        .waddr (wptr_q),
        .wdata (order_code),
        .raddr (rptr_q),
        .rdata (ord_rd)
    );

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            order_valid_q <= 1'b0;
            order_out_q   <= '0;
        end else if (ce) begin
            order_valid_q <= rd_pend_q;
            order_out_q   <= rd_pend_q ? ord_rd : order_out_q;
        end
    end

    a_clock_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && clock_ind_q && !full_reset) |=> clock_ind_q)
        else $error("clock error lost without full reset");

    a_parity_halt: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && parity_fail) |=> (halt_q && parity_ind_q && stop_ind_q))
        else $error("parity did not halt");

    a_fetch_ind: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && parity_fail && phase == cse_pkg::PH_FETCH) |=> (fetch_ind_q && !commit_en_q))
        else $error("fetch phase not shown");

    a_clock_flag: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && !full_reset && timing_fault && step_end) |=> (clock_ind_q && halt_q))
        else $error("clock error not flagged");

    a_file_ror: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && disk_write && disk_from_acc_ror) |=> file_ind_q)
        else $error("file check missed");

    a_cards_held: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && read_ind_q) |=> $stable(held2_q))
        else $error("held card moved");

    // delta mark and check light in continue mode.
    a_mark_cont: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && prn_error && prn_mode == cse_pkg::PM_MARK_CONT) |=> (delta_mark_q && prn_check_ind_q))
        else $error("mark continue wrong");

    a_stop_nodelta: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && prn_error && prn_mode == cse_pkg::PM_STOP) |=> !delta_mark_q)
        else $error("delta in stop mode");

    a_file_latch: assert property (@(posedge clk) disable iff (sys_rst)
        (ce && file_ind_q && !check_reset && !full_reset) |=> file_ind_q)
        else $error("file check dropped");
endmodule // cse_top
`default_nettype wire

// >>> verif/cse_prn_model.sv
`timescale 1ns/1ps
`default_nettype none
module cse_prn_model (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic go,
    input  wire logic with_err,
    output logic      line_start,
    output logic      line_err,
    output logic      line_done
);
    logic [2:0] step_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            step_q     <= 3'h0;
            line_start <= 1'b0;
            line_err   <= 1'b0;
            line_done  <= 1'b0;
        end else begin
            step_q     <= go ? 3'h1 : (step_q == 3'h0 ? 3'h0 : step_q + 3'h1);
            line_start <= go;
            line_err   <= with_err && step_q == 3'h1;
            line_done  <= step_q == 3'h3;
        end
    end
endmodule // cse_prn_model
`default_nettype wire

// >>> verif/cse_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cse_top_tb;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [16:0] ev = 17'h0;
    logic [1:0]  phase = 2'h0, prn_mode = 2'h0;
    logic [15:0] acc_value = 16'h0;
    logic        disk_compare_ok = 1'b1, disk_from_acc_ror = 1'b0, file_panel_wired = 1'b1;
    logic        feed_busy = 1'b0, periph_error = 1'b0;
    logic [7:0]  card_id = 8'h0, order_code = 8'h0;
    logic [3:0]  output_busy = 4'h0, output_dev = 4'h0;
    logic        halt_q, stop_ind_q, parity_ind_q, fetch_ind_q, source_ind_q, dest_ind_q, clock_ind_q;
    logic        file_ind_q, feed_ind_q, read_ind_q, ilock_ind_q, abandon_q, commit_en_q, acc_zero_q;
    logic        prn_check_ind_q, delta_mark_q, prn_reprint_q, prn_halt_q, order_valid_q;
    logic        ls, le, ld;
    logic [3:0]  select_ind_q;
    logic [15:0] core_q;
    logic [7:0]  order_out_q, held0_q, held1_q, held2_q;
    int          failures = 0, n_checks = 0, cyc = 0, w;
    logic [3:0]  ftab [4] = '{4'h5, 4'hf, 4'hc, 4'h9};
    logic [7:0]  olog [2];
    int          n_log = 0;

    always #5 clk = ~clk;

    cse_prn_model PRN (.clk, .sys_rst, .go(ev[16]), .with_err(1'b1), .line_start(ls), .line_err(le), .line_done(ld));

    cse_top DUT (.clk, .sys_rst, .ce(1'b1), .check_reset(ev[8]), .full_reset(ev[9]), .parity_fail(ev[0]), .phase,
        .step_end(ev[1]), .timing_fault(ev[2]), .acc_readout_reset(ev[10]), .acc_accumulate(ev[11]), .acc_value,
        .disk_write(ev[3]), .disk_compare_ok, .disk_from_acc_ror, .file_panel_wired, .feed_misfeed(ev[4]),
        .read_error(ev[5]), .card_in(ev[15]), .card_id, .input_track_access(ev[6]), .feed_busy,
        .output_track_write(ev[7]), .output_busy, .output_dev, .periph_error, .prn_mode, .prn_error(le),
        .prn_line_start(ls), .prn_line_done(ld), .prn_reset_check(ev[12]), .line_repeat(ev[13]),
        .order_push(ev[14]), .order_code, .halt_q, .stop_ind_q, .parity_ind_q, .fetch_ind_q, .source_ind_q,
        .dest_ind_q, .clock_ind_q, .file_ind_q, .feed_ind_q, .read_ind_q, .ilock_ind_q, .select_ind_q, .abandon_q,
        .commit_en_q, .acc_zero_q, .core_q, .prn_check_ind_q, .delta_mark_q, .prn_reprint_q, .prn_halt_q,
        .order_valid_q, .order_out_q, .held0_q, .held1_q, .held2_q);

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev <= 17'h0;
        #1;
    endtask

    task automatic results;
        if (failures == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            results;
        end
    end

    // Logs the first two orders handed out, so short valid pulses are never missed.
    always @(posedge clk) begin
        if (order_valid_q === 1'b1 && n_log < 2) begin
            olog[n_log] = order_out_q;
            n_log++;
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({halt_q, commit_en_q}, 2'h1);
        for (int ph = 0; ph < 3; ph++) begin
            acc_value = 16'h5a3c + 16'(ph);
            phase = 2'(ph);
            if (ph > 0) pulse(ph == 1 ? 10 : 11);
            pulse(0);
            repeat (3) @(posedge clk);
            #1;
            chk({halt_q, stop_ind_q, parity_ind_q, fetch_ind_q, source_ind_q, dest_ind_q}, {3'h7, 3'h4 >> ph});
            if (ph == 0) chk(commit_en_q, 1'b0);
            if (ph == 1) chk({acc_zero_q, core_q}, {1'b1, acc_value});
            if (ph == 2) chk(core_q, acc_value);
            pulse(8);
            chk({halt_q, parity_ind_q, fetch_ind_q, source_ind_q, dest_ind_q}, 5'h0);
        end
        pulse(2);
        pulse(1);
        chk({halt_q, clock_ind_q}, 2'h3);
        pulse(8);
        chk({halt_q, clock_ind_q}, 2'h3);
        pulse(9);
        chk({halt_q, clock_ind_q}, 2'h0);
        for (int i = 0; i < 4; i++) begin
            {disk_compare_ok, disk_from_acc_ror, file_panel_wired} = ftab[i][2:0];
            pulse(3);
            chk({halt_q, file_ind_q}, {2{ftab[i][3]}});
            pulse(8);
        end
        pulse(4);
        chk({halt_q, feed_ind_q}, 2'h3);
        pulse(8);
        for (int c = 1; c < 5; c++) begin
            card_id = 8'(c);
            pulse(15);
        end
        pulse(5);
        card_id = 8'h40;
        pulse(15);
        chk({halt_q, read_ind_q}, 2'h3);
        chk({held2_q, held1_q, held0_q}, 24'h020304);
        pulse(8);
        feed_busy = 1'b1;
        periph_error = 1'b1;
        pulse(6);
        chk({halt_q, ilock_ind_q, select_ind_q}, 6'h31);
        pulse(8);
        chk(abandon_q, 1'b1);
        {feed_busy, periph_error, output_busy, output_dev} = 10'h044;
        pulse(7);
        chk({halt_q, ilock_ind_q, select_ind_q}, 6'h34);
        pulse(8);
        output_busy = 4'h0;
        output_dev = 4'h2;
        for (int m = 0; m < 3; m++) begin
            prn_mode = 2'(m);
            pulse(16);
            repeat (2) @(posedge clk);
            #1;
            chk({delta_mark_q, prn_check_ind_q}, {m != 0, 1'b1});
            repeat (3) @(posedge clk);
            pulse(7);
            chk({halt_q, ilock_ind_q, select_ind_q[1], prn_halt_q}, {4{m != 2}});
            pulse(13);
            chk(prn_reprint_q, m != 2);
            n_log = 0;
            for (int k = 0; k < 2; k++) begin
                order_code = 8'h30 + 8'(k);
                pulse(14);
            end
            pulse(12);
            pulse(8);
            chk(prn_check_ind_q, 1'b0);
            w = 0;
            while (n_log < 2 && w < 40) begin
                @(posedge clk);
                #1;
                w++;
            end
            chk(n_log, 2);
            for (int k = 0; k < 2; k++) begin
                chk(olog[k], 8'h30 + 8'(k));
            end
        end
        results;
    end
endmodule // cse_top_tb
`default_nettype wire
